// ===== rtl/clk_ctrl_pkg.sv
// constants shared by the clock control block
package clk_ctrl_pkg;
    // ***************************************************************
    // register offsets (byte addresses, one word each)
    // ***************************************************************
    localparam logic [4:0] osc_ctrl_off   = 5'h00;
    localparam logic [4:0] clk_div_off    = 5'h04;
    localparam logic [4:0] pll_fbd_off    = 5'h08;
    localparam logic [4:0] rc_trim_off    = 5'h0C;
    localparam logic [4:0] pll_odiv_off   = 5'h10;
    localparam logic [4:0] unlock_off     = 5'h14;
    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int cur_src_lsb  = 12;
    localparam int new_src_lsb  = 8;
    localparam int fail_bit     = 3;
    localparam int switch_bit   = 0;
    localparam int roi_bit      = 15;
    localparam int doze_lsb     = 12;
    localparam int doze_en_bit  = 11;
    localparam int rcdiv_lsb    = 8;
    localparam int vco_lsb      = 8;
    localparam int post1_lsb    = 4;
    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [2:0] doze_rst     = 3'h3;
    localparam logic [2:0] rcdiv_rst    = 3'h0;
    localparam logic [3:0] pre_rst      = 4'h1;
    localparam logic [7:0] fbd_rst      = 8'h96;
    localparam logic [5:0] trim_rst     = 6'h00;
    localparam logic [1:0] vco_rst      = 2'h0;
    localparam logic [2:0] post1_rst    = 3'h4;
    localparam logic [2:0] post2_rst    = 3'h1;
    // unlock keys written to the unlock register
    localparam logic [7:0] key_hi_a     = 8'h78;
    localparam logic [7:0] key_hi_b     = 8'h9A;
    localparam logic [7:0] key_lo_a     = 8'h46;
    localparam logic [7:0] key_lo_b     = 8'h57;
    // source codes
    localparam logic [2:0] src_frc      = 3'h0;
    localparam logic [2:0] src_frc_pll  = 3'h1;
    localparam logic [2:0] src_pri_pll  = 3'h3;
    localparam logic [2:0] src_rsvd     = 3'h4;
    // clock switch settle time
    localparam int switch_ns     = 500;
    localparam int clk_ns        = 50;
    localparam int switch_cycles = (switch_ns + clk_ns - 1) / clk_ns;
endpackage

// ===== rtl/sync3.sv
// three stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 (
    input  wire logic sys_clk_in, // system clock
    input  wire logic sys_rst_in, // sync reset, high
    input  wire logic async_in,   // raw pin
    output logic      level_out   // filtered level
);
    typedef struct packed {
        logic [2:0] s;
        logic       lvl;
    } st_t;
    st_t st_q, st_d;
    // change counts once stage two and three agree
    always_comb begin
        st_d       = st_q;
        st_d.s     = {st_q.s[1:0], async_in};
        if (st_q.s[1] == st_q.s[2]) begin
            st_d.lvl = st_q.s[2];
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign level_out = st_q.lvl;
endmodule
`default_nettype wire

// ===== rtl/pulse_div.sv
// divider ratio tick generator: pulses once every ratio cycles
`timescale 1ns/1ps
`default_nettype none
module pulse_div (
    input  wire logic       sys_clk_in, // system clock
    input  wire logic       sys_rst_in, // sync reset, high
    input  wire logic [7:0] ratio_in,   // divide ratio minus one
    output logic            tick_out    // one cycle tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } st_t;
    st_t st_q, st_d;
    // counter wraps at the ratio
    always_comb begin
        st_d = st_q;
        if (st_q.cnt >= ratio_in) begin
            st_d.cnt  = 8'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt  = st_q.cnt + 8'h01;
            st_d.tick = 1'b0;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign tick_out = st_q.tick;
endmodule
`default_nettype wire

// ===== rtl/clk_ctrl.sv
// oscillator select, clock divider and pll settings register block
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl (
    input  wire logic        sys_clk_in,          // 20 MHz clock
    input  wire logic        sys_rst_in,          // sync reset, high
    input  wire logic [4:0]  avs_address,         // byte address
    input  wire logic        avs_read,            // read strobe
    input  wire logic        avs_write,           // write strobe
    input  wire logic [31:0] avs_writedata,       // write data
    input  wire logic [3:0]  avs_byteenable,      // byte lanes
    output logic [31:0]      avs_readdata,        // read data
    output logic             avs_waitrequest,     // wait
    input  wire logic [2:0]  reset_source_in,     // strap source code
    input  wire logic        monitor_fail_in,     // clock loss pin
    input  wire logic        irq_in,              // any interrupt
    output logic [2:0]       clk_select_out,      // active source
    output logic             clk_gate_out,        // low during swap
    output logic             fail_trap_out,       // failure trap
    output logic [2:0]       rc_postscaler_out,   // rc postscaler code
    output logic [5:0]       rc_trim_code_out,    // rc trim
    output logic [3:0]       pll_prescaler_out,   // pll prescaler
    output logic [7:0]       pll_feedback_value_out, // feedback divide
    output logic [1:0]       vco_output_divider_out, // vco divide
    output logic [2:0]       post_divider_one_out,   // post divide 1
    output logic [2:0]       post_divider_two_out,   // post divide 2
    output logic             cpu_clk_tick_out     // processor tick
);
    // ***************************************************************
    // state
    // ***************************************************************
    typedef enum logic [3:0] {
        sw_idle = 4'b0001,
        sw_gate = 4'b0010,
        sw_swap = 4'b0100,
        sw_done = 4'b1000
    } sw_state_t;

    typedef struct packed {
        sw_state_t   sw;
        logic [7:0]  sw_cnt;
        logic        strap_done;
        logic [2:0]  cur_src;
        logic [2:0]  new_src;
        logic        fail_flag;
        logic        switch_req;
        logic        unlock_hi;
        logic        unlock_hi_arm;
        logic        unlock_lo;
        logic        unlock_lo_arm;
        logic        recover_on_irq;
        logic [2:0]  doze;
        logic        reduction_enable;
        logic [2:0]  rc_postscaler;
        logic [3:0]  pll_prescaler;
        logic [7:0]  pll_feedback_value;
        logic [5:0]  rc_trim_code;
        logic [1:0]  vco_output_divider;
        logic [2:0]  post_divider_one;
        logic [2:0]  post_divider_two;
        logic        trap;
        logic        gate;
        logic        ack;
        logic [31:0] rdata;
    } st_t;

    st_t st_q, st_d;
    logic fail_lvl;
    logic fail_lvl_q;
    logic div_tick;
    logic [7:0] ratio;
    logic wr;
    logic rd;
    logic [15:0] wd;
    logic [15:0] osc_rd;
    logic [15:0] div_rd;

    // the fail pin is asynchronous to this clock
    sync3 u_fail_sync (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (monitor_fail_in),
        .level_out  (fail_lvl)
    );

    // ratio is 1:1 unless reduction is enabled
    always_comb begin
        if (st_q.reduction_enable) begin
            ratio = 8'((9'h001 << st_q.doze) - 9'h001);
        end else begin
            ratio = 8'h00;
        end
    end

    pulse_div u_doze (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .ratio_in   (ratio),
        .tick_out   (div_tick)
    );

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            fail_lvl_q <= 1'b0;
        end else begin
            fail_lvl_q <= fail_lvl;
        end
    end

    // ***************************************************************
    // bus decode: one wait cycle, answer on the second edge
    // ***************************************************************
    assign wr = avs_write & ~st_q.ack;
    assign rd = avs_read & ~st_q.ack;
    assign wd = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                 avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

    // readback with reserved positions zero
    assign osc_rd = {1'b0, st_q.cur_src, 1'b0, st_q.new_src,
                     4'h0, st_q.fail_flag, 2'b00, st_q.switch_req};
    assign div_rd = {st_q.recover_on_irq, st_q.doze,
                     st_q.reduction_enable, st_q.rc_postscaler,
                     4'h0, st_q.pll_prescaler};

    always_comb begin
        st_d     = st_q;
        st_d.ack = (avs_read | avs_write) & ~st_q.ack;
        // trap is a one cycle pulse; any set below wins over this
        st_d.trap = 1'b0;
        // windows and key arms last one write, so any write breaks them; reads leave them open
        if (wr) begin
            st_d.unlock_hi     = 1'b0;
            st_d.unlock_lo     = 1'b0;
            st_d.unlock_hi_arm = 1'b0;
            st_d.unlock_lo_arm = 1'b0;
        end
        // catch the strap after reset release
        if (!st_q.strap_done) begin
            st_d.strap_done = 1'b1;
            st_d.cur_src    = reset_source_in;
            st_d.new_src    = reset_source_in;
        end
        // register reads
        st_d.rdata = 32'h0000_0000;
        if (rd) begin
            if (avs_address == clk_ctrl_pkg::osc_ctrl_off) begin
                st_d.rdata = {16'h0000, osc_rd};
            end else if (avs_address == clk_ctrl_pkg::clk_div_off) begin
                st_d.rdata = {16'h0000, div_rd};
            end else if (avs_address == clk_ctrl_pkg::pll_fbd_off) begin
                st_d.rdata = {24'h00_0000, st_q.pll_feedback_value};
            end else if (avs_address == clk_ctrl_pkg::rc_trim_off) begin
                st_d.rdata = {26'h000_0000, st_q.rc_trim_code};
            end else if (avs_address == clk_ctrl_pkg::pll_odiv_off) begin
                st_d.rdata = {22'h00_0000, st_q.vco_output_divider,
                              1'b0, st_q.post_divider_one,
                              1'b0, st_q.post_divider_two};
            end else begin
                st_d.rdata = 32'h0000_0000;
            end
        end
        // register writes
        if (wr) begin
            if (avs_address == clk_ctrl_pkg::unlock_off) begin
                // two keys back to back open each byte
                st_d.unlock_hi_arm = (wd[15:8] == clk_ctrl_pkg::key_hi_a);
                st_d.unlock_lo_arm = (wd[7:0] == clk_ctrl_pkg::key_lo_a);
                st_d.unlock_hi = st_q.unlock_hi_arm &&
                                 wd[15:8] == clk_ctrl_pkg::key_hi_b;
                st_d.unlock_lo = st_q.unlock_lo_arm &&
                                 wd[7:0] == clk_ctrl_pkg::key_lo_b;
            end else if (avs_address == clk_ctrl_pkg::osc_ctrl_off) begin
                st_d.unlock_hi_arm = 1'b0;
                st_d.unlock_lo_arm = 1'b0;
                if (st_q.unlock_hi && avs_byteenable[1]) begin
                    st_d.new_src = wd[10:8];
                end
                if (st_q.unlock_lo && avs_byteenable[0]) begin
                    st_d.fail_flag = wd[3];
                    if (wd[3] && !st_q.fail_flag) begin
                        st_d.trap = 1'b1;
                    end
                    if (wd[0]) begin
                        st_d.switch_req = 1'b1;
                    end
                end
            end else if (avs_address == clk_ctrl_pkg::clk_div_off) begin
                if (avs_byteenable[1]) begin
                    st_d.recover_on_irq = wd[15];
                    st_d.rc_postscaler = wd[10:8];
                    if (!st_q.reduction_enable) begin
                        st_d.doze = wd[14:12];
                    end
                    // enable needs a nonzero field, as it ends up
                    st_d.reduction_enable = wd[11] &&
                                            st_d.doze != 3'h0;
                end
                if (avs_byteenable[0]) begin
                    st_d.pll_prescaler = wd[3:0];
                end
            end else if (avs_address == clk_ctrl_pkg::pll_fbd_off) begin
                if (avs_byteenable[0]) begin
                    st_d.pll_feedback_value = wd[7:0];
                end
            end else if (avs_address == clk_ctrl_pkg::rc_trim_off) begin
                if (avs_byteenable[0]) begin
                    st_d.rc_trim_code = wd[5:0];
                end
            end else if (avs_address == clk_ctrl_pkg::pll_odiv_off) begin
                if (avs_byteenable[1]) begin
                    st_d.vco_output_divider = wd[9:8];
                end
                if (avs_byteenable[0]) begin
                    st_d.post_divider_one = wd[6:4];
                    st_d.post_divider_two = wd[2:0];
                end
            end else begin
                st_d.unlock_hi_arm = 1'b0;
            end
        end
        // recover on interrupt drops reduction back to 1:1
        if (irq_in && st_q.recover_on_irq) begin
            st_d.reduction_enable = 1'b0;
        end
        // hardware set of the fail flag wins over a clear
        if (fail_lvl && !fail_lvl_q) begin
            st_d.fail_flag = 1'b1;
            st_d.trap      = 1'b1;
        end
        // switch sequence: gate clock, swap, ungate, then clear request
        case (st_q.sw)
            sw_idle: begin
                if (st_q.switch_req) begin
                    st_d.sw     = sw_gate;
                    st_d.gate   = 1'b1;
                    st_d.sw_cnt = 8'h00;
                end
            end
            sw_gate: begin
                st_d.sw_cnt = st_q.sw_cnt + 8'h01;
                if (st_q.sw_cnt ==
                    8'(clk_ctrl_pkg::switch_cycles - 1)) begin
                    st_d.sw      = sw_swap;
                    // reserved code falls back to plain fast rc
                    st_d.cur_src = (st_q.new_src == clk_ctrl_pkg::src_rsvd)
                                   ? clk_ctrl_pkg::src_frc
                                   : st_q.new_src;
                end
            end
            sw_swap: begin
                st_d.gate = 1'b0;
                st_d.sw   = sw_done;
            end
            sw_done: begin
                st_d.switch_req = 1'b0;
                st_d.sw         = sw_idle;
            end
            default: begin
                st_d.sw = sw_idle;
            end
        endcase
    end

    // ***************************************************************
    // state register
    // ***************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_q                    <= '0;
            st_q.sw                 <= sw_idle;
            st_q.doze               <= clk_ctrl_pkg::doze_rst;
            st_q.rc_postscaler      <= clk_ctrl_pkg::rcdiv_rst;
            st_q.pll_prescaler      <= clk_ctrl_pkg::pre_rst;
            st_q.pll_feedback_value <= clk_ctrl_pkg::fbd_rst;
            st_q.rc_trim_code       <= clk_ctrl_pkg::trim_rst;
            st_q.vco_output_divider <= clk_ctrl_pkg::vco_rst;
            st_q.post_divider_one   <= clk_ctrl_pkg::post1_rst;
            st_q.post_divider_two   <= clk_ctrl_pkg::post2_rst;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from state flops
    assign avs_readdata           = st_q.rdata;
    assign avs_waitrequest        = ~st_q.ack;
    assign clk_select_out         = st_q.cur_src;
    assign clk_gate_out           = ~st_q.gate;
    assign fail_trap_out          = st_q.trap;
    assign rc_postscaler_out      = st_q.rc_postscaler;
    assign rc_trim_code_out       = st_q.rc_trim_code;
    assign pll_prescaler_out      = st_q.pll_prescaler;
    assign pll_feedback_value_out = st_q.pll_feedback_value;
    assign vco_output_divider_out = st_q.vco_output_divider;
    assign post_divider_one_out   = st_q.post_divider_one;
    assign post_divider_two_out   = st_q.post_divider_two;
    assign cpu_clk_tick_out       = div_tick;

    // ***************************************************************
    // checks
    // ***************************************************************
    chk_fail_sets: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) (fail_lvl && !fail_lvl_q) |=> st_q.fail_flag)
        else $error("fail flag not set");
    chk_sw_trap: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        (st_q.fail_flag && !$past(st_q.fail_flag)) |-> st_q.trap)
        else $error("no trap on flag set");
    chk_sw_clears: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        (st_q.sw == sw_idle && st_q.switch_req) |-> ##[1:40] !st_q.switch_req)
        else $error("switch never finished");
    chk_locked_src: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        (!st_q.unlock_hi && st_q.strap_done) |=> $stable(st_q.new_src))
        else $error("source changed while locked");
    chk_irq_recover: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        (irq_in && st_q.recover_on_irq) |=> !st_q.reduction_enable)
        else $error("interrupt did not recover");
    chk_ratio_one: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        !st_q.reduction_enable |-> ratio == 8'h00 ##1 div_tick)
        else $error("ratio not 1:1");
    chk_doze_hold: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        ($past(st_q.reduction_enable) && st_q.reduction_enable)
        |-> $stable(st_q.doze))
        else $error("field changed while enabled");
    chk_en_nonzero: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        st_q.reduction_enable |-> st_q.doze != 3'h0)
        else $error("enable with zero field");
    chk_gate_ends: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        (st_q.sw == sw_swap) |=> !st_q.gate ##1 !st_q.switch_req)
        else $error("switch tail wrong");
endmodule
`default_nettype wire

// ===== sim/oscillator_pll_clock_divider_test.sv
// self-checking bench for the clock control register block
`timescale 1ns/1ps
`default_nettype none
`define chk(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error at %0t: got %h want %h", $time, a, e); end end
module oscillator_pll_clock_divider_test;
    logic        sys_clk_in      = 1'b0;
    logic        sys_rst_in      = 1'b1;
    logic [4:0]  avs_address     = 5'h00;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0000_0000;
    logic [3:0]  avs_byteenable  = 4'h0;
    logic        monitor_fail_in = 1'b0;
    logic        irq_in          = 1'b0;
    logic [2:0]  strap_src       = 3'h7;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  clk_select_out, rc_postscaler_out, post1, post2;
    logic        clk_gate_out, fail_trap_out, cpu_clk_tick_out;
    logic [5:0]  rc_trim_code_out;
    logic [3:0]  pll_prescaler_out;
    logic [7:0]  fbd_out;
    logic [1:0]  vco_out;
    logic [31:0] rd;
    int          error_cnt = 0;
    int          checks = 0;
    int          tick_cnt = 0;
    int          trap_cnt = 0;
    clk_ctrl dut_u (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .reset_source_in(strap_src),
        .monitor_fail_in(monitor_fail_in), .irq_in(irq_in),
        .clk_select_out(clk_select_out), .clk_gate_out(clk_gate_out),
        .fail_trap_out(fail_trap_out),
        .rc_postscaler_out(rc_postscaler_out),
        .rc_trim_code_out(rc_trim_code_out),
        .pll_prescaler_out(pll_prescaler_out),
        .pll_feedback_value_out(fbd_out), .vco_output_divider_out(vco_out),
        .post_divider_one_out(post1), .post_divider_two_out(post2),
        .cpu_clk_tick_out(cpu_clk_tick_out));
    // 20 MHz clock
    initial begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    // count one-cycle pulses; nba keeps reads race free
    always @(posedge sys_clk_in) begin
        if (cpu_clk_tick_out === 1'b1) tick_cnt <= tick_cnt + 1;
        if (fail_trap_out === 1'b1) trap_cnt <= trap_cnt + 1;
    end
    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic finish_test;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [15:0] d, input logic [3:0] be);
        int n;
        @(posedge sys_clk_in);
        avs_write <= w;
        avs_read <= ~w;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            finish_test;
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000, 4'hF);
        `chk(rd, {16'h0000, e})
    endtask
    // unlock one byte of oscillator control, then write that byte
    task automatic oscw(input logic hi, input logic [15:0] d);
        if (hi) begin
            bus(1'b1, clk_ctrl_pkg::unlock_off, 16'h7800, 4'h2);
            bus(1'b1, clk_ctrl_pkg::unlock_off, 16'h9A00, 4'h2);
        end else begin
            bus(1'b1, clk_ctrl_pkg::unlock_off, 16'h0046, 4'h1);
            bus(1'b1, clk_ctrl_pkg::unlock_off, 16'h0057, 4'h1);
        end
        bus(1'b1, clk_ctrl_pkg::osc_ctrl_off, d, hi ? 4'h2 : 4'h1);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic reset_values;
        logic [15:0] rv [6];
        rv = '{16'h7700, 16'h3001, 16'h0096, 16'h0000, 16'h0041, 16'h0000};
        for (int i = 0; i < 6; i++) begin
            rchk((i == 5) ? 5'h18 : 5'(i * 4), rv[i]);
        end
        `chk(post1, 3'h4)
        `chk(fbd_out, 8'h96)
    endtask
    // walk every source code; pll modes never adjacent
    task automatic switch_all;
        logic [2:0] c;
        bus(1'b1, clk_ctrl_pkg::osc_ctrl_off, 16'h0500, 4'h2);
        rchk(clk_ctrl_pkg::osc_ctrl_off, 16'h7700);
        for (int i = 1; i < 9; i++) begin
            c = 3'(i);
            oscw(1'b1, {5'h00, c, 8'h00});
            oscw(1'b0, 16'h0001);
            repeat (3) @(posedge sys_clk_in);
            `chk(clk_gate_out, 1'b0)
            repeat (15) @(posedge sys_clk_in);
            if (c == 3'h4) c = 3'h0;
            `chk(clk_select_out, c)
            rchk(clk_ctrl_pkg::osc_ctrl_off, {1'b0, c, 1'b0, 3'(i), 8'h00});
        end
    endtask
    task automatic clock_fail;
        int t;
        t = trap_cnt;
        monitor_fail_in <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        monitor_fail_in <= 1'b0;
        rchk(clk_ctrl_pkg::osc_ctrl_off, 16'h0008);
        `chk(trap_cnt, t + 1)
        repeat (8) @(posedge sys_clk_in);
        oscw(1'b0, 16'h0000);
        rchk(clk_ctrl_pkg::osc_ctrl_off, 16'h0000);
        oscw(1'b0, 16'h0008);
        repeat (4) @(posedge sys_clk_in);
        `chk(trap_cnt, t + 2)
    endtask
    task automatic pll_fields;
        bus(1'b1, clk_ctrl_pkg::pll_fbd_off, 16'hFF10, 4'h3);
        rchk(clk_ctrl_pkg::pll_fbd_off, 16'h0010);
        bus(1'b1, clk_ctrl_pkg::rc_trim_off, 16'h0020, 4'h3);
        rchk(clk_ctrl_pkg::rc_trim_off, 16'h0020);
        bus(1'b1, clk_ctrl_pkg::pll_odiv_off, 16'hFF77, 4'h3);
        rchk(clk_ctrl_pkg::pll_odiv_off, 16'h0377);
        bus(1'b1, clk_ctrl_pkg::clk_div_off, 16'h0738, 4'h3);
        rchk(clk_ctrl_pkg::clk_div_off, 16'h0708);
        `chk({post1, post2, vco_out}, 8'hFF)
        `chk({rc_postscaler_out, pll_prescaler_out}, 7'h78)
        `chk({fbd_out, rc_trim_code_out}, 14'h0420)
    endtask
    // reduction: lock, divide, recover on interrupt, zero field
    task automatic doze;
        int t;
        bus(1'b1, clk_ctrl_pkg::clk_div_off, 16'hD800, 4'h3);
        bus(1'b1, clk_ctrl_pkg::clk_div_off, 16'h9800, 4'h3);
        rchk(clk_ctrl_pkg::clk_div_off, 16'hD800);
        t = tick_cnt;
        repeat (64) @(posedge sys_clk_in);
        `chk(tick_cnt - t, 2)
        irq_in <= 1'b1;
        @(posedge sys_clk_in);
        irq_in <= 1'b0;
        rchk(clk_ctrl_pkg::clk_div_off, 16'hD000);
        t = tick_cnt;
        repeat (16) @(posedge sys_clk_in);
        `chk(tick_cnt - t, 16)
        bus(1'b1, clk_ctrl_pkg::clk_div_off, 16'h0800, 4'h3);
        rchk(clk_ctrl_pkg::clk_div_off, 16'h0000);
        bus(1'b1, clk_ctrl_pkg::clk_div_off, 16'h1800, 4'h3);
        irq_in <= 1'b1;
        @(posedge sys_clk_in);
        irq_in <= 1'b0;
        rchk(clk_ctrl_pkg::clk_div_off, 16'h1800);
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        reset_values;
        switch_all;
        clock_fail;
        pll_fields;
        doze;
        finish_test;
    end
endmodule
`default_nettype wire
